// ===== pkg/pfc_pkg.sv
// Shared constants and carrier types for the flow control credit block.
// Assumes one 250 MHz core clock and a synchronous active-high reset.
package pfc_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NCLS = 6;
	localparam int NTYPE = 3;
	localparam int CW = 12;
	localparam int BEAT_W = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int QTR_SHIFT = 2;
	localparam int TMR_W = 16;

	// ****************************************
	// Class and packet type codes
	// ****************************************
	localparam logic [1:0] KIND_P = 2'h0;
	localparam logic [1:0] KIND_NP = 2'h1;
	localparam logic [1:0] KIND_CPL = 2'h2;
	localparam int CLS_PH = 0;
	localparam int CLS_PD = 1;
	localparam int CLS_NPH = 2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int FC_TIMER_NS = 30000;
	localparam int FC_TIMER_CYC = FC_TIMER_NS * 1000 / CLK_PERIOD_PS;

	// ****************************************
	// Defaults
	// ****************************************
	localparam int MAXPAY_CRED = 16;
	localparam logic [CW-1:0] CRED_ONE = 12'h001;
	localparam logic [CW-1:0] CRED_ZERO = 12'h000;

	// ****************************************
	// Carriers
	// ****************************************
	typedef logic [NCLS-1:0][CW-1:0] pfc_cred6_t;

	typedef struct packed {
		logic [1:0] kind;
		logic [CW-1:0] hdr;
		logic [CW-1:0] dat;
	} pfc_dllp_t;

	typedef struct packed {
		logic [BEAT_W-1:0] data;
		logic last;
		logic [1:0] kind;
		logic [CW-1:0] dcred;
	} pfc_beat_t;

	localparam pfc_cred6_t RXBUF_DEF = {12'h040, 12'h020, 12'h020, 12'h010, 12'h080, 12'h020};
endpackage

// ===== hw/pfc_fifo.sv
// Small valid/ready FIFO holding received beats.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pfc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;

	wire logic push = in_valid_i && in_ready_o;
	wire logic pop = out_valid_o && out_ready_i;

	assign in_ready_o = count != FULL_CNT;
	assign out_valid_o = count != '0;
	assign out_data_o = mem[rd_ptr];

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == LAST_PTR) ? '0 : AW'(p + 1'b1);
	endfunction

	// ****************************************
	// Storage and pointers
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i; // [R07]
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= ptr_inc(wr_ptr);
			if (pop)
				rd_ptr <= ptr_inc(rd_ptr);
			count <= (AW+1)'(count + push - pop);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_fifo_hold;
		@(posedge clk_i) disable iff (srst_i)
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o);
	endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("beat lost before drain"); // [R07]

	c_fifo_full: cover property (@(posedge clk_i) disable iff (srst_i) !in_ready_o);
endmodule
`default_nettype wire

// ===== hw/pfc_credits.sv
// Credit based flow control: transmit credit gating and receive credit return.
// Assumes link layer supplies decoded FC DLLPs and a TLP busy indication.
//
// What this block does
// R01: Separate limit and consumed counters for six header and data classes.
// R02: Limit loads at flow control init, then follows received updates.
// R03: Packet goes only if limit minus consumed covers its need or its class was granted zero (unlimited) credit at init, else held.
// R04: Header and data checked separately; a packet costs one header credit.
// R05: Accepted packet adds its credits to header and data consumed counters.
// R06: Receive allocated counters start at each class's buffer size.
// R07: Received beats are buffered until the application drains them.
// R08: Allocated counters rise only after a packet's last beat is drained.
// R09: Update DLLP carries the current allocated values.
// R10: Update DLLPs go at low priority behind other pending traffic.
// R11: High priority when partner nearly starved and new credit exists.
// R12: High priority when 30 us passed since the last update sent.
// R13: High priority when new credit reaches a quarter of buffer size.
// R14: Update never interrupts a TLP in flight; it waits for its end.
// R15: Received update refreshes the limit and releases held packets.
// R16: Buffer sizes and partner grants must cover several TLPs in flight.
// R17: Endpoint advertises unlimited completion credit; no completion updates.
// R18: Remember the allocated values carried by the last sent update.
`timescale 1ns/1ps
`default_nettype none
module pfc_credits
	import pfc_pkg::*;
#(
	parameter pfc_pkg::pfc_cred6_t RXBUF_CRED = pfc_pkg::RXBUF_DEF,
	parameter int MAXPAY = pfc_pkg::MAXPAY_CRED,
	parameter int TIMER_CYC = pfc_pkg::FC_TIMER_CYC,
	parameter bit ENDPOINT = 1'b1,
	parameter int DEPTH = pfc_pkg::FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic fcinit_valid_i,
	input wire pfc_pkg::pfc_cred6_t fcinit_i,
	input wire logic fcupd_valid_i,
	input wire pfc_pkg::pfc_dllp_t fcupd_i,
	input wire logic tx_valid_i,
	input wire logic [1:0] tx_kind_i,
	input wire logic [pfc_pkg::CW-1:0] tx_dcred_i,
	output logic tx_ready_o,
	input wire logic rx_valid_i,
	input wire pfc_pkg::pfc_beat_t rx_beat_i,
	output logic rx_ready_o,
	output logic app_valid_o,
	output pfc_pkg::pfc_beat_t app_beat_o,
	input wire logic app_ready_i,
	input wire logic tlp_busy_i,
	input wire logic other_req_i,
	output logic dllp_valid_o,
	output logic dllp_hipri_o,
	output pfc_pkg::pfc_dllp_t dllp_o,
	input wire logic dllp_ready_i
);
	import pfc_pkg::*;

	localparam logic [TMR_W-1:0] TMR_END = TMR_W'(TIMER_CYC);
	localparam logic [CW-1:0] MAXPAY_C = CW'(MAXPAY);

	logic [CW-1:0] limit [NCLS];
	logic [CW-1:0] cons [NCLS];
	logic [CW-1:0] alloc [NCLS];
	logic [CW-1:0] last_adv [NCLS];
	logic [CW-1:0] rcvd [NCLS];
	logic inf [NCLS];
	logic [NCLS-1:0] ok;
	logic [NCLS-1:0] chg;
	logic [NCLS-1:0] hi;
	logic [3:0] pend;
	logic [3:0] hi_t;
	logic [TMR_W-1:0] tmr;
	logic out_full;
	pfc_dllp_t out_q;
	pfc_beat_t fifo_out;

	function automatic logic [1:0] first_idx(input logic [3:0] v);
		first_idx = v[0] ? 2'h0 : (v[1] ? 2'h1 : (v[2] ? 2'h2 : 2'h3));
	endfunction

	// ****************************************
	// Handshakes
	// ****************************************
	wire logic tx_fire = tx_valid_i && tx_ready_o;
	wire logic rx_fire = rx_valid_i && rx_ready_o;
	wire logic app_fire = app_valid_o && app_ready_i;
	wire logic send = dllp_valid_o && dllp_ready_i;
	wire logic tmr_exp = tmr >= TMR_END;

	assign tx_ready_o = tx_valid_i && (&ok); // [R03] [R15]
	assign app_beat_o = fifo_out;

	// ****************************************
	// Receive buffer
	// ****************************************
	pfc_fifo #(
		.W($bits(pfc_beat_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_valid_i(rx_valid_i),
		.in_ready_o(rx_ready_o),
		.in_data_i(rx_beat_i),
		.out_valid_o(app_valid_o),
		.out_ready_i(app_ready_i),
		.out_data_o(fifo_out)
	); // [R07]

	// ****************************************
	// Per class counters
	// ****************************************
	for (genvar g = 0; g < NCLS; g++)
	begin : g_cls
		localparam logic [1:0] KIND = 2'(g / 2);
		localparam bit IS_DAT = (g % 2) == 1;
		localparam logic [CW-1:0] THR = IS_DAT ? MAXPAY_C : CRED_ONE;
		localparam logic [CW-1:0] QTR = RXBUF_CRED[g] >> QTR_SHIFT;
		wire logic [CW-1:0] need = IS_DAT ? tx_dcred_i : CRED_ONE; // [R04]
		wire logic [CW-1:0] avail = limit[g] - cons[g];
		wire logic hit = tx_kind_i == KIND;
		wire logic [CW-1:0] rx_amt = IS_DAT ? rx_beat_i.dcred : CRED_ONE;
		wire logic [CW-1:0] app_amt = IS_DAT ? fifo_out.dcred : CRED_ONE;
		wire logic rx_hit = rx_fire && rx_beat_i.last && rx_beat_i.kind == KIND;
		wire logic app_hit = app_fire && fifo_out.last && fifo_out.kind == KIND;
		wire logic [CW-1:0] adv_q = IS_DAT ? out_q.dat : out_q.hdr;
		wire logic [CW-1:0] upd_v = IS_DAT ? fcupd_i.dat : fcupd_i.hdr;
		wire logic cond_a = ((last_adv[g] - rcvd[g]) < THR) && chg[g];
		wire logic cond_c = (alloc[g] - last_adv[g]) >= QTR;

		assign ok[g] = !hit || inf[g] || (avail >= need); // [R03] [R04]
		assign chg[g] = alloc[g] != last_adv[g];
		assign hi[g] = cond_a || cond_c; // [R11] [R13]

		always_ff @(posedge clk_i)
		begin
			if (srst_i)
			begin
				limit[g] <= CRED_ZERO;
				inf[g] <= 1'b0;
			end
			else if (fcinit_valid_i)
			begin
				limit[g] <= fcinit_i[g]; // [R02]
				inf[g] <= fcinit_i[g] == CRED_ZERO;
			end
			else if (fcupd_valid_i && fcupd_i.kind == KIND)
				limit[g] <= upd_v; // [R02] [R15]
		end

		always_ff @(posedge clk_i)
		begin
			if (srst_i)
				cons[g] <= CRED_ZERO;
			else if (tx_fire && hit)
				cons[g] <= cons[g] + need; // [R01] [R05]
		end

		always_ff @(posedge clk_i)
		begin
			if (srst_i)
				alloc[g] <= RXBUF_CRED[g]; // [R06] [R16]
			else if (app_hit)
				alloc[g] <= alloc[g] + app_amt; // [R08]
		end

		always_ff @(posedge clk_i)
		begin
			if (srst_i)
				rcvd[g] <= CRED_ZERO;
			else if (rx_hit)
				rcvd[g] <= rcvd[g] + rx_amt;
		end

		always_ff @(posedge clk_i)
		begin
			if (srst_i)
				last_adv[g] <= RXBUF_CRED[g];
			else if (send && out_q.kind == KIND)
				last_adv[g] <= adv_q; // [R18]
		end
	end

	// ****************************************
	// Update request per type
	// ****************************************
	for (genvar k = 0; k < NTYPE; k++)
	begin : g_type
		localparam bit CINF = ENDPOINT && (2'(k) == KIND_CPL);
		assign pend[k] = !CINF && (chg[2*k] || chg[2*k+1] || tmr_exp); // [R17]
		assign hi_t[k] = !CINF && (hi[2*k] || hi[2*k+1] || tmr_exp); // [R12]
	end
	assign pend[3] = 1'b0;
	assign hi_t[3] = 1'b0;

	wire logic [3:0] pend_hi = pend & hi_t;
	wire logic [1:0] sel = (|pend_hi) ? first_idx(pend_hi) : first_idx(pend);
	wire logic [2:0] sel_h = {sel, 1'b0};
	wire logic [2:0] sel_d = {sel, 1'b1};
	wire logic load = !out_full && (|pend);
	wire logic hi_now = out_full && hi_t[out_q.kind];

	// ****************************************
	// Update DLLP output stage
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			out_full <= 1'b0;
			out_q <= '0;
		end
		else if (load)
		begin
			out_full <= 1'b1;
			out_q <= '{kind: sel, hdr: alloc[sel_h], dat: alloc[sel_d]}; // [R09]
		end
		else if (send)
			out_full <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i || send)
			tmr <= '0;
		else if (!tmr_exp)
			tmr <= TMR_W'(tmr + 1'b1); // [R12]
	end

	assign dllp_valid_o = out_full && !tlp_busy_i && (hi_now || !other_req_i); // [R10] [R14]
	assign dllp_hipri_o = hi_now;
	assign dllp_o = out_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	property p_no_cut;
		tlp_busy_i |-> !dllp_valid_o;
	endproperty
	a_no_cut: assert property (p_no_cut) else $error("update sent during TLP"); // [R14]

	property p_low_pri;
		dllp_valid_o && !dllp_hipri_o |-> !other_req_i;
	endproperty
	a_low_pri: assert property (p_low_pri) else $error("low priority update beat traffic"); // [R10]

	property p_hold;
		tx_valid_i && tx_kind_i == KIND_P && !inf[CLS_PH] && limit[CLS_PH] == cons[CLS_PH]
			|-> !tx_ready_o;
	endproperty
	a_hold: assert property (p_hold) else $error("packet sent without header credit"); // [R03]

	property p_hdr_cons;
		tx_fire && tx_kind_i == KIND_NP |=> cons[CLS_NPH] == $past(cons[CLS_NPH]) + CRED_ONE;
	endproperty
	a_hdr_cons: assert property (p_hdr_cons) else $error("header consumed not one"); // [R04]

	property p_dat_cons;
		tx_fire && tx_kind_i == KIND_P |=> cons[CLS_PD] == $past(cons[CLS_PD]) + $past(tx_dcred_i);
	endproperty
	a_dat_cons: assert property (p_dat_cons) else $error("data consumed wrong"); // [R05]

	property p_upd_lim;
		fcupd_valid_i && !fcinit_valid_i && fcupd_i.kind == KIND_P
			|=> limit[CLS_PD] == $past(fcupd_i.dat);
	endproperty
	a_upd_lim: assert property (p_upd_lim) else $error("limit not updated"); // [R15]

	property p_ret;
		app_fire && fifo_out.last && fifo_out.kind == KIND_NP
			|=> alloc[CLS_NPH] == $past(alloc[CLS_NPH]) + CRED_ONE;
	endproperty
	a_ret: assert property (p_ret) else $error("credit not returned"); // [R08]

	property p_adv;
		load && sel == KIND_P |=> out_full && dllp_o.dat == $past(alloc[CLS_PD]);
	endproperty
	a_adv: assert property (p_adv) else $error("update value not current"); // [R09]

	property p_last;
		send && dllp_o.kind == KIND_P |=> last_adv[CLS_PH] == $past(dllp_o.hdr);
	endproperty
	a_last: assert property (p_last) else $error("last sent not recorded"); // [R18]

	property p_timer;
		tmr_exp && out_full && out_q.kind != KIND_CPL |-> dllp_hipri_o;
	endproperty
	a_timer: assert property (p_timer) else $error("timer did not raise priority"); // [R12]

	property p_qtr;
		out_full && out_q.kind == KIND_P
			&& (alloc[CLS_PD] - last_adv[CLS_PD]) >= (RXBUF_CRED[CLS_PD] >> QTR_SHIFT)
			|-> dllp_hipri_o;
	endproperty
	a_qtr: assert property (p_qtr) else $error("quarter threshold missed"); // [R13]

	property p_cpl;
		ENDPOINT && out_full |-> out_q.kind != KIND_CPL;
	endproperty
	a_cpl: assert property (p_cpl) else $error("completion update issued"); // [R17]

	property p_init;
		$past(srst_i) |-> alloc[CLS_PD] == RXBUF_CRED[CLS_PD];
	endproperty
	a_init: assert property (p_init) else $error("allocated not at buffer size"); // [R06]

	c_held: cover property (tx_valid_i && !tx_ready_o ##[1:50] tx_fire);
	c_hi_send: cover property (send && dllp_hipri_o && other_req_i);
	c_timer: cover property (tmr_exp && send);
	c_ret: cover property (app_fire && fifo_out.last ##[1:20] send);
endmodule
`default_nettype wire

// ===== test/pfc_remote.sv
// Remote port model: takes update DLLPs promptly or after a stall.
// Assumes the block's clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pfc_remote
	import pfc_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic slow_i,
	input wire logic dllp_valid_i,
	input wire pfc_pkg::pfc_dllp_t dllp_i,
	output logic dllp_ready_o,
	output logic [7:0] took_o,
	output logic cpl_seen_o
);
	logic [1:0] wait_cnt;
	// Slow mode answers after three waiting cycles
	assign dllp_ready_o = dllp_valid_i && (!slow_i || wait_cnt == 2'h3);
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wait_cnt <= 2'h0;
			took_o <= 8'h00;
			cpl_seen_o <= 1'b0;
		end
		else if (dllp_ready_o)
		begin
			wait_cnt <= 2'h0;
			took_o <= took_o + 8'h01;
			cpl_seen_o <= cpl_seen_o | (dllp_i.kind == KIND_CPL);
		end
		else if (dllp_valid_i)
			wait_cnt <= wait_cnt + 2'h1;
	end
endmodule
`default_nettype wire

// ===== test/tb_pfc_credits.sv
// Self-checking bench for the flow control credit block.
// Assumes the package and the remote port model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
$display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_pfc_credits;
	import pfc_pkg::*;
	localparam int TMR = 300;
	typedef struct packed {
		logic [1:0] k;
		logic [CW-1:0] d;
		logic r;
	} pfc_row_t;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic fcinit_valid_i = 1'b0;
	pfc_cred6_t fcinit_i = '0;
	logic fcupd_valid_i = 1'b0;
	pfc_dllp_t fcupd_i = '0;
	logic tx_valid_i = 1'b0;
	logic [1:0] tx_kind_i = 2'h0;
	logic [CW-1:0] tx_dcred_i = 12'h000;
	logic rx_valid_i = 1'b0;
	pfc_beat_t rx_beat_i = '0;
	logic app_ready_i = 1'b0;
	logic tlp_busy_i = 1'b0;
	logic other_req_i = 1'b0;
	logic slow = 1'b0;
	logic tx_ready_o, rx_ready_o, app_valid_o, dllp_valid_o, dllp_hipri_o, dllp_ready_i;
	logic cpl_seen;
	logic [7:0] took;
	pfc_beat_t app_beat_o;
	pfc_dllp_t dllp_o;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	pfc_row_t rows [7] = '{'{KIND_P, 12'h004, 1'b1}, '{KIND_P, 12'h004, 1'b1},
		'{KIND_P, 12'h000, 1'b0}, '{KIND_NP, 12'h005, 1'b0}, '{KIND_NP, 12'h004, 1'b1},
		'{KIND_NP, 12'h000, 1'b0}, '{KIND_CPL, 12'h064, 1'b1}};

	pfc_credits #(.TIMER_CYC(TMR)) pfc_credits_i (.clk_i(clk_i), .srst_i(srst_i),
		.fcinit_valid_i(fcinit_valid_i), .fcinit_i(fcinit_i), .fcupd_valid_i(fcupd_valid_i),
		.fcupd_i(fcupd_i), .tx_valid_i(tx_valid_i), .tx_kind_i(tx_kind_i),
		.tx_dcred_i(tx_dcred_i), .tx_ready_o(tx_ready_o), .rx_valid_i(rx_valid_i),
		.rx_beat_i(rx_beat_i), .rx_ready_o(rx_ready_o), .app_valid_o(app_valid_o),
		.app_beat_o(app_beat_o), .app_ready_i(app_ready_i), .tlp_busy_i(tlp_busy_i),
		.other_req_i(other_req_i), .dllp_valid_o(dllp_valid_o), .dllp_hipri_o(dllp_hipri_o),
		.dllp_o(dllp_o), .dllp_ready_i(dllp_ready_i));
	pfc_remote pfc_remote_i (.clk_i(clk_i), .srst_i(srst_i), .slow_i(slow),
		.dllp_valid_i(dllp_valid_o), .dllp_i(dllp_o), .dllp_ready_o(dllp_ready_i),
		.took_o(took), .cpl_seen_o(cpl_seen));

	initial
	begin
		forever #2 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic step();
		@(posedge clk_i);
		#1;
	endtask

	task automatic push(input logic [31:0] d, input logic [1:0] k, input logic [CW-1:0] c);
		rx_beat_i = '{data: d, last: 1'b1, kind: k, dcred: c};
		rx_valid_i = 1'b1;
		n = 0;
		while (!rx_ready_o && n < 20)
		begin
			step();
			n++;
		end
		step();
		rx_valid_i = 1'b0;
		rx_beat_i = ~rx_beat_i;
	endtask

	task automatic pop();
		app_ready_i = 1'b1;
		n = 0;
		while (!app_valid_o && n < 20)
		begin
			step();
			n++;
		end
		step();
		app_ready_i = 1'b0;
	endtask

	task automatic wait_dllp();
		n = 0;
		while (!dllp_valid_o && n < 20)
		begin
			step();
			n++;
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (3) step();
		srst_i = 1'b0;
		#1;
		`CHK("reset", 4'h4, {tx_ready_o, rx_ready_o, app_valid_o, dllp_valid_o})
		`CHK("reset_dllp", 26'h0, dllp_o)
		// ****************************************
		// Transmit gating table
		// ****************************************
		fcinit_i = {12'h000, 12'h000, 12'h004, 12'h001, 12'h008, 12'h002};
		fcinit_valid_i = 1'b1;
		step();
		fcinit_valid_i = 1'b0;
		foreach (rows[i])
		begin
			tx_valid_i = 1'b1;
			tx_kind_i = rows[i].k;
			tx_dcred_i = rows[i].d;
			#1;
			`CHK("tx_ready", rows[i].r, tx_ready_o)
			step();
		end
		// ****************************************
		// Hand-written cases
		// ****************************************
		tx_kind_i = KIND_P;
		tx_dcred_i = 12'h004;
		fcupd_i = '{kind: KIND_P, hdr: 12'h003, dat: 12'h00c};
		#1;
		`CHK("held", 1'b0, tx_ready_o)
		fcupd_valid_i = 1'b1;
		step();
		fcupd_valid_i = 1'b0;
		#1;
		`CHK("released", 1'b1, tx_ready_o)
		step();
		`CHK("spent", 1'b0, tx_ready_o)
		tx_valid_i = 1'b0;
		other_req_i = 1'b1;
		push(32'ha1, KIND_P, 12'h004);
		repeat (3) step();
		`CHK("undrained", 1'b0, dllp_valid_o)
		pop();
		repeat (4) step();
		`CHK("lowpri", 1'b0, dllp_valid_o)
		other_req_i = 1'b0;
		#1;
		wait_dllp();
		`CHK("upd", {1'b0, KIND_P, 12'h021, 12'h084}, {dllp_hipri_o, dllp_o})
		step();
		for (int i = 0; i < 4; i++)
			push(32'(i), KIND_CPL, 12'h008);
		`CHK("full", 1'b0, rx_ready_o)
		rx_beat_i = '{data: 32'h99, last: 1'b1, kind: KIND_CPL, dcred: 12'h008};
		rx_valid_i = 1'b1;
		step();
		rx_valid_i = 1'b0;
		rx_beat_i = ~rx_beat_i;
		app_ready_i = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			`CHK("app", {1'b1, 32'(i)}, {app_valid_o, app_beat_o.data})
			step();
		end
		app_ready_i = 1'b0;
		`CHK("empty", 1'b0, app_valid_o)
		repeat (6) step();
		`CHK("no_cpl", 2'h0, {dllp_valid_o, cpl_seen})
		push(32'h55, KIND_P, 12'h020);
		tlp_busy_i = 1'b1;
		slow = 1'b1;
		pop();
		repeat (4) step();
		`CHK("busy", 1'b0, dllp_valid_o)
		tlp_busy_i = 1'b0;
		#1;
		wait_dllp();
		repeat (2) step();
		`CHK("quarter", {2'h3, KIND_P, 12'h022, 12'h0a4}, {dllp_valid_o, dllp_hipri_o, dllp_o})
		n = 0;
		while (dllp_valid_o && n < 10)
		begin
			step();
			n++;
		end
		slow = 1'b0;
		n = 0;
		while (!dllp_valid_o && n < TMR + 20)
		begin
			step();
			n++;
		end
		`CHK("timer", 2'h3, {n >= TMR - 3 && n <= TMR + 3, dllp_hipri_o})
		step();
		report_and_stop();
	end
endmodule
`default_nettype wire
